// File: core/trs_defines.svh
/*
 * Offsets, field positions, reset values and sizes of the ring switch.
 * Assumes word addressing on the register port, one register per address.
 */
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

// ==========================================================
// Sizes
`define TRS_ADDR_W 16
`define TRS_DATA_W 16
`define TRS_LINKS 16
`define TRS_CFG_W 12

// ==========================================================
// Register offsets
`define TRS_OFS_CTRL 16'h0180
`define TRS_OFS_TX0 16'h0181
`define TRS_OFS_STAT 16'h0191
`define TRS_OFS_RX0 16'h01C0

// ==========================================================
// Control fields
`define TRS_CTRL_EN 2
`define TRS_CTRL_INIT 1
`define TRS_CTRL_MASTER 0
`define TRS_CTRL_W 3

// ==========================================================
// Link fields
`define TRS_LNK_ATM_ON 11
`define TRS_LNK_ATM_HI 10
`define TRS_LNK_ATM_LO 6
`define TRS_LNK_TDM_ON 5
`define TRS_LNK_TDM_HI 4
`define TRS_LNK_TDM_LO 0

// ==========================================================
// Reset values, fixed bytes and status lock bit
`define TRS_CTRL_RST 3'h0
`define TRS_LNK_RST 12'h000
`define TRS_EMPTY_HDR 8'h00
`define TRS_STAT_LOCK 8

`endif

// File: core/trs_pkg.sv
/*
 * Types shared by the ring switch modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package trs_pkg;
  typedef logic [7:0] trs_byte_t;
  typedef logic [4:0] trs_slot_t;
  typedef enum logic [3:0] {
    trs_off = 4'h1,
    trs_init = 4'h2,
    trs_master = 4'h4,
    trs_member = 4'h8
  } trs_mode_t;
endpackage : trs_pkg
`default_nettype wire

// File: core/trs_slot_if.sv
/*
 * Ring slot bus: current slot number and the ring byte in it.
 * Assumes one driver (the top) and many per-link switch readers.
 */
`timescale 1ns/100ps
`default_nettype none
interface trs_slot_if;
  logic active;
  trs_pkg::trs_slot_t slot;
  trs_pkg::trs_byte_t ring_byte;
  modport src (output active, output slot, output ring_byte);
  modport sink (input active, input slot, input ring_byte);
endinterface : trs_slot_if
`default_nettype wire

// File: core/trs_ring_switch.sv
/*
 * One link's ring switch: an add point (local byte onto the ring) and a
 * drop point (ring byte to the local path), each on its own side.
 * Assumes the slot bus is synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "trs_defines.svh"
module trs_ring_switch #(
  parameter bit ADD_IS_ATM = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  trs_slot_if.sink slot_bus,
  input wire logic [`TRS_CFG_W-1:0] cfg,
  input wire logic [7:0] add_src,
  input wire logic [7:0] drop_norm,
  output logic add_hit,
  output logic [7:0] add_byte,
  output logic [7:0] drop_out
);
  logic atm_on;
  logic tdm_on;
  logic add_on;
  logic drop_on;
  trs_pkg::trs_slot_t add_adr;
  trs_pkg::trs_slot_t drop_adr;
  trs_pkg::trs_byte_t cap_q, cap_d;
  trs_pkg::trs_byte_t out_q, out_d;

  // ==========================================================
  // Field split
  assign atm_on = cfg[`TRS_LNK_ATM_ON];
  assign tdm_on = cfg[`TRS_LNK_TDM_ON];
  assign add_on = ADD_IS_ATM ? atm_on : tdm_on;
  assign drop_on = ADD_IS_ATM ? tdm_on : atm_on;
  assign add_adr = ADD_IS_ATM ? cfg[`TRS_LNK_ATM_HI:`TRS_LNK_ATM_LO]
                              : cfg[`TRS_LNK_TDM_HI:`TRS_LNK_TDM_LO];
  assign drop_adr = ADD_IS_ATM ? cfg[`TRS_LNK_TDM_HI:`TRS_LNK_TDM_LO]
                               : cfg[`TRS_LNK_ATM_HI:`TRS_LNK_ATM_LO];

  // ==========================================================
  // Add and drop
  // Address is gated by the side bit, so a stale address is inert
  assign add_hit = add_on && slot_bus.active &&
                   (slot_bus.slot == add_adr);
  assign add_byte = add_on ? add_src : 8'h00;

  always_comb begin
    cap_d = cap_q;
    if (drop_on && slot_bus.active && slot_bus.slot == drop_adr) begin
      cap_d = slot_bus.ring_byte;
    end
    out_d = drop_on ? cap_q : drop_norm;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_q <= 8'h00;
      out_q <= 8'h00;
    end else begin
      cap_q <= cap_d;
      out_q <= out_d;
    end
  end
  assign drop_out = out_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_drop_normal: assert property (
    !drop_on |=> drop_out == $past(drop_norm))
    else $error("normal path not passed through");
  chk_add_gated: assert property (
    !add_on |-> !add_hit && add_byte == 8'h00)
    else $error("disabled add point reached the ring");
endmodule : trs_ring_switch
`default_nettype wire

// File: core/trs_ring_top.sv
/*
 * Ring configuration registers and per-link ring switching.
 * Assumes ring pins are asynchronous to clk; link data is on clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "trs_defines.svh"

// Operation
// - Enable bit 2 low tri-states ring outputs; high drives them.
// - Init bit 1 makes the master send empty headers; members ignore it.
// - Master bit 0 makes this device ring master, else a member.
// - Transmit bit 11 joins the ring to the control-cell modifier path.
// - Transmit bits 10:6 hold the ATM-side ring address.
// - Transmit bit 5 joins the ring to the TDM transmit interface.
// - Transmit bits 4:0 hold the TDM-side ring address.
// - Receive bit 11 joins the ring to the receive link group logic.
// - Receive bits 10:6 hold the ATM-side ring address.
// - Receive bit 5 joins the TDM receive interface to the ring.
// - Receive bits 4:0 hold the TDM-side ring address.
module trs_ring_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`TRS_ADDR_W-1:0] reg_addr,
  input wire logic [`TRS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`TRS_DATA_W-1:0] reg_rdata,
  input wire logic [7:0] ring_in_data,
  input wire logic ring_in_sync,
  output logic [7:0] ring_out_data,
  output logic ring_out_sync,
  output logic ring_out_oe,
  input wire logic [`TRS_LINKS-1:0][7:0] tx_mod_data,
  output logic [`TRS_LINKS-1:0][7:0] tx_tdm_data,
  input wire logic [`TRS_LINKS-1:0][7:0] rx_tdm_data,
  output logic [`TRS_LINKS-1:0][7:0] rx_grp_data
);
  // ==========================================================
  // Declarations
  logic [7:0] rin_s1_q, rin_s2_q;
  logic rsync_s1_q, rsync_s2_q;
  logic [`TRS_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [`TRS_LINKS-1:0][`TRS_CFG_W-1:0] tx_q, tx_d;
  logic [`TRS_LINKS-1:0][`TRS_CFG_W-1:0] rx_q, rx_d;
  logic [`TRS_DATA_W-1:0] rdata_q, rdata_d;
  trs_pkg::trs_mode_t mode_q, mode_d;
  trs_pkg::trs_slot_t slot_q, slot_d, slot_cur;
  logic lock_q, lock_d;
  logic [7:0] out_data_q, out_data_d;
  logic out_sync_q, out_sync_d;
  logic out_oe_q, out_oe_d;
  logic [`TRS_LINKS-1:0] tx_hit, rx_hit;
  logic [`TRS_LINKS-1:0][7:0] tx_add, rx_add;
  logic any_hit;
  logic [7:0] add_sel;

  trs_slot_if slot_bus ();

  // ==========================================================
  // Ring pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rin_s1_q <= 8'h00;
      rin_s2_q <= 8'h00;
      rsync_s1_q <= 1'b0;
      rsync_s2_q <= 1'b0;
    end else begin
      rin_s1_q <= ring_in_data;
      rin_s2_q <= rin_s1_q;
      rsync_s1_q <= ring_in_sync;
      rsync_s2_q <= rsync_s1_q;
    end
  end

  // ==========================================================
  // Register file
  always_comb begin
    ctrl_d = ctrl_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rdata_d = 16'h0000;
    if (reg_wr) begin
      if (reg_addr == `TRS_OFS_CTRL) begin
        ctrl_d = reg_wdata[`TRS_CTRL_W-1:0];
      end
      for (int i = 0; i < `TRS_LINKS; i++) begin
        if (reg_addr == `TRS_OFS_TX0 + 16'(i)) begin
          tx_d[i] = reg_wdata[`TRS_CFG_W-1:0];
        end
        if (reg_addr == `TRS_OFS_RX0 + 16'(i)) begin
          rx_d[i] = reg_wdata[`TRS_CFG_W-1:0];
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == `TRS_OFS_CTRL) begin
        rdata_d = {13'h0000, ctrl_q};
      end
      if (reg_addr == `TRS_OFS_STAT) begin
        rdata_d = {7'h00, lock_q, 3'h0, slot_q};
      end
      for (int i = 0; i < `TRS_LINKS; i++) begin
        if (reg_addr == `TRS_OFS_TX0 + 16'(i)) begin
          rdata_d = {4'h0, tx_q[i]};
        end
        if (reg_addr == `TRS_OFS_RX0 + 16'(i)) begin
          rdata_d = {4'h0, rx_q[i]};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `TRS_CTRL_RST;
      tx_q <= {`TRS_LINKS{`TRS_LNK_RST}};
      rx_q <= {`TRS_LINKS{`TRS_LNK_RST}};
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // Ring role
  // Two masters on one ring would fight over slot timing; software
  // must prevent it, the device cannot see the other nodes
  always_comb begin
    if (!ctrl_d[`TRS_CTRL_EN]) begin
      mode_d = trs_pkg::trs_off;
    end else if (!ctrl_d[`TRS_CTRL_MASTER]) begin
      mode_d = trs_pkg::trs_member;
    end else if (ctrl_d[`TRS_CTRL_INIT]) begin
      mode_d = trs_pkg::trs_init;
    end else begin
      mode_d = trs_pkg::trs_master;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= trs_pkg::trs_off;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // Slot timing
  // Master runs free; a member realigns to every received sync
  always_comb begin
    slot_cur = slot_q;
    lock_d = lock_q;
    unique case (mode_q)
      trs_pkg::trs_member: begin
        if (rsync_s2_q) begin
          slot_cur = 5'h00;
          lock_d = 1'b1;
        end
      end
      trs_pkg::trs_init, trs_pkg::trs_master: lock_d = 1'b1;
      trs_pkg::trs_off: lock_d = 1'b0;
    endcase
    slot_d = 5'(slot_cur + 5'h01);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_q <= 5'h00;
      lock_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      lock_q <= lock_d;
    end
  end

  // Init frames carry only empty headers, so no link may add then
  assign slot_bus.active = lock_q &&
                           (mode_q == trs_pkg::trs_master ||
                            mode_q == trs_pkg::trs_member);
  assign slot_bus.slot = slot_cur;
  assign slot_bus.ring_byte = rin_s2_q;

  // ==========================================================
  // Per-link switches
  for (genvar g = 0; g < `TRS_LINKS; g++) begin : g_link
    // Transmit: modifier adds at ATM address, TDM drops at TDM address
    trs_ring_switch #(.ADD_IS_ATM(1'b1)) u_tx (
      .clk(clk),
      .rst(rst),
      .slot_bus(slot_bus),
      .cfg(tx_q[g]),
      .add_src(tx_mod_data[g]),
      .drop_norm(tx_mod_data[g]),
      .add_hit(tx_hit[g]),
      .add_byte(tx_add[g]),
      .drop_out(tx_tdm_data[g])
    );
    // Receive: TDM adds at TDM address, group drops at ATM address
    trs_ring_switch #(.ADD_IS_ATM(1'b0)) u_rx (
      .clk(clk),
      .rst(rst),
      .slot_bus(slot_bus),
      .cfg(rx_q[g]),
      .add_src(rx_tdm_data[g]),
      .drop_norm(rx_tdm_data[g]),
      .add_hit(rx_hit[g]),
      .add_byte(rx_add[g]),
      .drop_out(rx_grp_data[g])
    );
  end

  // ==========================================================
  // Ring output
  // Overlapping addresses: lowest transmit link wins, then receive
  always_comb begin
    any_hit = 1'b0;
    add_sel = 8'h00;
    for (int i = `TRS_LINKS - 1; i >= 0; i--) begin
      if (rx_hit[i]) begin
        any_hit = 1'b1;
        add_sel = rx_add[i];
      end
    end
    for (int i = `TRS_LINKS - 1; i >= 0; i--) begin
      if (tx_hit[i]) begin
        any_hit = 1'b1;
        add_sel = tx_add[i];
      end
    end
  end

  always_comb begin
    out_oe_d = ctrl_q[`TRS_CTRL_EN];
    out_data_d = 8'h00;
    out_sync_d = 1'b0;
    unique case (mode_q)
      trs_pkg::trs_off: begin
        out_data_d = 8'h00;
      end
      trs_pkg::trs_init: begin
        out_data_d = `TRS_EMPTY_HDR;
        out_sync_d = (slot_cur == 5'h00);
      end
      trs_pkg::trs_master: begin
        out_data_d = any_hit ? add_sel : rin_s2_q;
        out_sync_d = (slot_cur == 5'h00);
      end
      trs_pkg::trs_member: begin
        out_data_d = any_hit ? add_sel : rin_s2_q;
        out_sync_d = rsync_s2_q;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data_q <= 8'h00;
      out_sync_q <= 1'b0;
      out_oe_q <= 1'b0;
    end else begin
      out_data_q <= out_data_d;
      out_sync_q <= out_sync_d;
      out_oe_q <= out_oe_d;
    end
  end
  assign ring_out_data = out_data_q;
  assign ring_out_sync = out_sync_q;
  assign ring_out_oe = out_oe_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_oe_follows_en: assert property (
    reg_wr && reg_addr == `TRS_OFS_CTRL ##1 !reg_wr
    |=> ring_out_oe == $past(ctrl_q[`TRS_CTRL_EN]))
    else $error("ring output enable does not follow control");
  chk_off_quiet: assert property (
    !ctrl_q[`TRS_CTRL_EN] |=> !ring_out_oe && ring_out_data == 8'h00)
    else $error("ring driven while disabled");
  chk_init_header: assert property (
    mode_q == trs_pkg::trs_init |=> ring_out_data == `TRS_EMPTY_HDR)
    else $error("master in init sent a non-empty header");
  chk_member_forward: assert property (
    mode_q == trs_pkg::trs_member && !any_hit
    |=> ring_out_data == $past(rin_s2_q))
    else $error("member did not forward ring byte");
  chk_master_sync: assert property (
    mode_q == trs_pkg::trs_master
    |=> ring_out_sync == ($past(slot_cur) == 5'h00))
    else $error("master sync not at slot zero");
  chk_member_sync: assert property (
    mode_q == trs_pkg::trs_member |=> ring_out_sync == $past(rsync_s2_q))
    else $error("member sync not forwarded");
  chk_slot_step: assert property (
    mode_q == trs_pkg::trs_master && $past(mode_q) == trs_pkg::trs_master
    |-> slot_q == 5'($past(slot_q) + 5'h01))
    else $error("master slot counter did not advance");
  chk_tx_store: assert property (
    reg_wr && reg_addr == `TRS_OFS_TX0
    |=> tx_q[0] == $past(reg_wdata[`TRS_CFG_W-1:0]))
    else $error("transmit link write lost");
  chk_upper_zero: assert property (
    reg_rd |=> reg_rdata[15:12] == 4'h0)
    else $error("unused upper bits read nonzero");
  chk_rd_window: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  cov_init: cover property (mode_q == trs_pkg::trs_init ##1
                            mode_q == trs_pkg::trs_master);
  cov_member_lock: cover property (mode_q == trs_pkg::trs_member
                                   && rsync_s2_q);
  cov_add: cover property (any_hit ##1 ring_out_oe);
  cov_both_add: cover property (|tx_hit && |rx_hit);
endmodule : trs_ring_top
`default_nettype wire

// File: testbench/trs_ring_peer.sv
/*
 * Upstream ring neighbour acting as ring master, one byte per clock.
 * Assumes the device under test is a ring member while en is high.
 */
`timescale 1ns/100ps
`default_nettype none
module trs_ring_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  output logic [7:0] ring_data,
  output logic ring_sync
);
  logic [4:0] slot_q;
  // ==========================================================
  // Slot counter and ring bytes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_q <= 5'h0;
      ring_data <= 8'h00;
      ring_sync <= 1'b0;
    end else if (en) begin
      slot_q <= slot_q + 5'h1;
      ring_data <= {3'h6, slot_q};
      ring_sync <= (slot_q == 5'h0);
    end else begin
      // Released line has no pull, so it keeps changing
      ring_data <= ~ring_data;
      ring_sync <= 1'b0;
    end
  end
endmodule : trs_ring_peer
`default_nettype wire

// File: testbench/tdm_ring_link_switch_config_tb_top.sv
/*
 * Self-checking bench of the ring configuration registers and switches.
 * Assumes one 200 MHz clock and the peer model upstream on the ring.
 */
`timescale 1ns/100ps
`default_nettype none
module tdm_ring_link_switch_config_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic peer_en = 1'b0;
  logic [7:0] rin_data;
  logic rin_sync;
  logic [7:0] rout_data;
  logic rout_sync;
  logic rout_oe;
  logic [15:0][7:0] tx_mod = '0;
  logic [15:0][7:0] rx_tdm = '0;
  logic [15:0][7:0] tx_tdm;
  logic [15:0][7:0] rx_grp;
  int fail_count = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  trs_ring_peer PEER (.clk(clk), .rst(rst), .en(peer_en),
    .ring_data(rin_data), .ring_sync(rin_sync));

  trs_ring_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ring_in_data(rin_data),
    .ring_in_sync(rin_sync), .ring_out_data(rout_data),
    .ring_out_sync(rout_sync), .ring_out_oe(rout_oe),
    .tx_mod_data(tx_mod), .tx_tdm_data(tx_tdm),
    .rx_tdm_data(rx_tdm), .rx_grp_data(rx_grp));

  // ==========================================================
  // Shared tasks
  task conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd_chk

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task wait_sync();
    for (int i = 0; i < 200; i++) begin
      step(1);
      if (rout_sync === 1'b1)
        return;
    end
    fail_count++;
    conclude();
  endtask : wait_sync

  // ==========================================================
  // Scenarios
  task t_regs();
    rd_chk(16'h0180, 16'h0000);
    rd_chk(16'h01CF, 16'h0000);
    wr(16'h0180, 16'hFFF8);
    rd_chk(16'h0180, 16'h0000);
    wr(16'h0190, 16'hFFFF);
    rd_chk(16'h0190, 16'h0FFF);
    wr(16'h01CF, 16'hF7DF);
    rd_chk(16'h01CF, 16'h07DF);
    wr(16'h0200, 16'hFFFF);
    rd_chk(16'h0200, 16'h0000);
    wr(16'h0190, 16'h0000);
    wr(16'h01CF, 16'h0000);
  endtask : t_regs

  task t_enable();
    wr(16'h0180, 16'h0000);
    step(2);
    check(rout_oe, 1'b0);
    check(rout_data, 8'h00);
    wr(16'h0180, 16'h0004);
    step(2);
    check(rout_oe, 1'b1);
  endtask : t_enable

  // Member with the init bit set, which a member ignores
  task t_member();
    @(posedge clk);
    peer_en <= 1'b1;
    tx_mod[0] <= 8'hA5;
    tx_mod[2] <= 8'h5A;
    rx_tdm[3] <= 8'h3C;
    rx_tdm[4] <= 8'h77;
    wr(16'h0181, 16'h0940);
    wr(16'h0182, 16'h0023);
    wr(16'h0183, 16'h07C7);
    wr(16'h01C2, 16'h09C0);
    wr(16'h01C3, 16'h0029);
    wr(16'h01C4, 16'h07C9);
    wr(16'h0180, 16'h0006);
    step(80);
    wait_sync();
    step(5);
    check(rout_data, 8'hA5);
    step(4);
    check(rout_data, 8'h3C);
    step(40);
    check(tx_tdm[1], 8'hC3);
    check(rx_grp[2], 8'hC7);
    check(tx_tdm[0], 8'hA5);
    check(tx_tdm[2], 8'h5A);
    check(rx_grp[4], 8'h77);
    rd_chk(16'h0181, 16'h0940);
  endtask : t_member

  task t_master();
    int syncs;
    logic [7:0] seen_or;
    // Upstream neighbour stops mastering before this device takes over
    @(posedge clk);
    peer_en <= 1'b0;
    wr(16'h0180, 16'h0005);
    step(40);
    wait_sync();
    step(5);
    check(rout_data, 8'hA5);
    step(27);
    check(rout_sync, 1'b1);
    wr(16'h0180, 16'h0007);
    step(4);
    syncs = 0;
    seen_or = 8'h00;
    for (int i = 0; i < 64; i++) begin
      step(1);
      if (rout_sync === 1'b1)
        syncs++;
      seen_or = seen_or | rout_data;
    end
    check(16'(syncs), 16'h0002);
    check(seen_or, 8'h00);
    // Leaving init must bring the link adds back in run mode
    wr(16'h0180, 16'h0005);
    wait_sync();
    step(5);
    check(rout_data, 8'hA5);
  endtask : t_master

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_enable();
    t_member();
    t_master();
    conclude();
  end
endmodule : tdm_ring_link_switch_config_tb_top
`default_nettype wire
